// >>> verilog/itfl_pkg.sv
// Purpose: Shared constants for the input terminal function logic.
// Assumes: 100 MHz clock, 8 terminals, 8-bit function codes.
// Notes:   Gains are in 0.1 percent units; frequencies in 0.01 Hz units.
package itfl_pkg;
  // ****************************************
  // Terminal function codes
  // ****************************************
  localparam logic [7:0] ITFL_FN_SET2   = 8'h08;
  localparam logic [7:0] ITFL_FN_TRIP   = 8'h0C;
  localparam logic [7:0] ITFL_FN_THIRD_SET_SELECT   = 8'h11;
  localparam logic [7:0] ITFL_FN_START  = 8'h14;
  localparam logic [7:0] ITFL_FN_STOP   = 8'h15;
  localparam logic [7:0] ITFL_FN_DIR    = 8'h16;
  localparam logic [7:0] ITFL_FN_GAIN   = 8'h1A;
  localparam logic [7:0] ITFL_FN_RAISE  = 8'h1B;
  localparam logic [7:0] ITFL_FN_LOWER  = 8'h1C;
  localparam logic [7:0] ITFL_FN_CLEAR  = 8'h1D;
  localparam logic [7:0] ITFL_FN_HOLD   = 8'h41;
  localparam logic [7:0] ITFL_FN_FWD    = 8'h00;
  localparam logic [7:0] ITFL_FN_REV    = 8'h01;
  localparam logic [7:0] ITFL_FN_NONE   = 8'hFF;
  // ****************************************
  // Setting encodings
  // ****************************************
  localparam logic [1:0] ITFL_SRC_TERM  = 2'h1;
  localparam logic [1:0] ITFL_SRC_OPER  = 2'h2;
  localparam logic [1:0] ITFL_MEM_ON    = 2'h1;
  localparam logic [1:0] ITFL_RUN_TERM  = 2'h1;
  localparam logic [2:0] ITFL_CM_VEC_LO = 3'h3;
  localparam logic [2:0] ITFL_CM_VEC_HI = 3'h5;
  localparam logic [7:0] ITFL_TRIP_CODE = 8'h0C;
  // ****************************************
  // Limits and timing
  // ****************************************
  localparam logic [13:0] ITFL_TAPER_MAX_MS = 14'd9999;
  localparam logic [13:0] ITFL_GAIN_MAX     = 14'd10000;
  localparam int          ITFL_CLK_MHZ      = 100;
  localparam int          ITFL_MS_CYCLES    = ITFL_CLK_MHZ * 1000;
  localparam logic [15:0] ITFL_FREQ_RESET   = 16'h0000;
  localparam int          ITFL_STEP_W       = 24;
endpackage

// >>> verilog/itfl_terminal_logic.sv
// Contract
// - Raise/lower works only when both raise and lower codes are assigned.
// - Raise/lower acts for terminal source with hold, or operator source.
// - Raise/lower ignored for analog source; jog frequency never altered.
// - Ramp set while adjusting chosen by second-set and third-set terminals.
// - Memory setting 01 retains adjusted frequency; 00 does not.
// - Clear terminal sets stored adjusted frequency to zero hertz.
// - Raise and lower together hold the present frequency.
// - Trip terminal enters trip state, reports code 12, shuts output.
// - External trip stays latched until drive reset.
// - Three-wire control applies only with run source 01.
// - Three-wire uses momentary start, momentary stop, direction terminals.
// - Assigned momentary stop disables forward and reverse run inputs.
// - Gain switching applies only in control methods 03 to 05.
// - Gain switch off uses motor gains; on uses alternate gains.
// - Unassigned gain switch behaves as permanently deasserted.
// - Gain change tapers over 0 to 9999 milliseconds.
// - Gain parameters above 1000 percent are rejected; the P-only gains are not checked against this limit.
// - Analog hold freezes analog command; adjustment relative to held value.
//
// Purpose: Decode eight configurable input terminals into drive controls.
// Assumes: Terminal inputs already debounced and synchronous to mclk_i.
// Notes:   Ramp rate is a per-cycle step picked from three input steps.
`timescale 1ns/1ps
module itfl_terminal_logic
  import itfl_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  arst_n_i,
  input  wire logic [7:0]            terminal_i,
  input  wire logic [63:0]           terminal_function_assign_i,
  input  wire logic [1:0]            frequency_source_setting_i,
  input  wire logic [1:0]            run_source_setting_i,
  input  wire logic [1:0]            adjust_memory_setting_i,
  input  wire logic [2:0]            control_method_select_i,
  input  wire logic                  drive_reset_i,
  input  wire logic                  jog_active_i,
  input  wire logic [15:0]           analog_freq_i,
  input  wire logic [15:0]           operator_freq_i,
  input  wire logic [15:0]           max_freq_i,
  input  wire logic [ITFL_STEP_W-1:0] ramp_step1_i,
  input  wire logic [ITFL_STEP_W-1:0] ramp_step2_i,
  input  wire logic [ITFL_STEP_W-1:0] ramp_step3_i,
  input  wire logic [13:0]           pi_prop_gain_param_i,
  input  wire logic [13:0]           pi_integral_gain_param_i,
  input  wire logic [13:0]           p_only_gain_param_i,
  input  wire logic [13:0]           alt_pi_prop_gain_i,
  input  wire logic [13:0]           alt_pi_integral_gain_i,
  input  wire logic [13:0]           alt_p_only_gain_i,
  input  wire logic [13:0]           gain_taper_time_i,
  output logic [15:0]                adjusted_freq_o,
  output logic                       adjust_active_o,
  output logic [1:0]                 ramp_set_o,
  output logic                       trip_o,
  output logic [7:0]                 trip_code_o,
  output logic                       output_enable_o,
  output logic                       run_o,
  output logic                       reverse_o,
  output logic [13:0]                kp_o,
  output logic [13:0]                ki_o,
  output logic [13:0]                kpp_o,
  output logic                       gain_alt_o,
  output logic                       param_error_o
);
  // ****************************************
  // Terminal decode
  // ****************************************
  logic [7:0] hit_raise, hit_lower, hit_clear, hit_trip, hit_start, hit_stop;
  logic [7:0] hit_dir, hit_gain, hit_set2, hit_third_set_select, hit_hold, hit_fwd, hit_rev;
  logic [7:0] asg_raise, asg_lower, asg_stop, asg_gain;

  // Each terminal matches its own function code; unassigned functions stay low.
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_term
      logic [7:0] fn;
      assign fn           = terminal_function_assign_i[g*8 +: 8];
      assign asg_raise[g] = (fn == ITFL_FN_RAISE);
      assign asg_lower[g] = (fn == ITFL_FN_LOWER);
      assign asg_stop[g]  = (fn == ITFL_FN_STOP);
      assign asg_gain[g]  = (fn == ITFL_FN_GAIN);
      assign hit_raise[g] = asg_raise[g] & terminal_i[g];
      assign hit_lower[g] = asg_lower[g] & terminal_i[g];
      assign hit_clear[g] = (fn == ITFL_FN_CLEAR) & terminal_i[g];
      assign hit_trip[g]  = (fn == ITFL_FN_TRIP) & terminal_i[g];
      assign hit_start[g] = (fn == ITFL_FN_START) & terminal_i[g];
      assign hit_stop[g]  = asg_stop[g] & terminal_i[g];
      assign hit_dir[g]   = (fn == ITFL_FN_DIR) & terminal_i[g];
      assign hit_gain[g]  = asg_gain[g] & terminal_i[g];
      assign hit_set2[g]  = (fn == ITFL_FN_SET2) & terminal_i[g];
      assign hit_third_set_select[g]  = (fn == ITFL_FN_THIRD_SET_SELECT) & terminal_i[g];
      assign hit_hold[g]  = (fn == ITFL_FN_HOLD) & terminal_i[g];
      assign hit_fwd[g]   = (fn == ITFL_FN_FWD) & terminal_i[g];
      assign hit_rev[g]   = (fn == ITFL_FN_REV) & terminal_i[g];
    end
  endgenerate

  // Per-function levels, the OR of every terminal that carries the code.
  logic raise, lower, clear, ext_trip, start, stop_in, dir, gain_sw;
  logic set2, third_set_select, hold, fwd, rev, stop_assigned;
  assign raise         = |hit_raise;
  assign lower         = |hit_lower;
  assign clear         = |hit_clear;
  assign ext_trip      = |hit_trip;
  assign start         = |hit_start;
  assign stop_in       = |hit_stop;
  assign dir           = |hit_dir;
  assign gain_sw       = |hit_gain;
  assign set2          = |hit_set2;
  assign third_set_select          = |hit_third_set_select;
  assign hold          = |hit_hold;
  assign fwd           = |hit_fwd;
  assign rev           = |hit_rev;
  assign stop_assigned = |asg_stop;

  // ****************************************
  // Remote raise/lower adjustment
  // ****************************************
  logic updown_ok, adj_enable;
  // Both functions must be assigned, and the source must allow adjustment.
  assign updown_ok = (|asg_raise) & (|asg_lower);
  assign adj_enable = updown_ok & ~jog_active_i &
                      ((frequency_source_setting_i == ITFL_SRC_OPER) |
                       ((frequency_source_setting_i == ITFL_SRC_TERM) & hold));

  // Ramp set select; third set wins over second when both are on.
  assign ramp_set_o = third_set_select ? 2'd2 : (set2 ? 2'd1 : 2'd0);
  // Step used while adjusting; the two unused sets are simply not selected.
  logic [ITFL_STEP_W-1:0] step;
  always_comb
  begin
    unique case (ramp_set_o)
      2'd1:    step = ramp_step2_i;
      2'd2:    step = ramp_step3_i;
      default: step = ramp_step1_i;
    endcase
  end

  logic [15:0] held_analog_r;
  logic        hold_d_r;
  // Held analog reference is captured on the rising edge of the hold input.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      held_analog_r <= ITFL_FREQ_RESET;
      hold_d_r      <= 1'b0;
    end
    else
    begin
      hold_d_r <= hold;
      if (hold & ~hold_d_r)
        held_analog_r <= analog_freq_i;
    end
  end

  // Offset has 8 fraction bits so slow ramps still advance.
  logic signed [31:0] offset_r, offset_nxt, base_s, upper_s, lower_s, cand;
  logic               adjusting;
  assign base_s    = (frequency_source_setting_i == ITFL_SRC_TERM) ?
                     {8'h00, held_analog_r, 8'h00} : {8'h00, operator_freq_i, 8'h00};
  assign upper_s   = {8'h00, max_freq_i, 8'h00} - base_s;
  assign lower_s   = 32'sd0 - base_s;
  assign adjusting = adj_enable & (raise ^ lower);
  assign adjust_active_o = adjusting;

  always_comb
  begin
    cand       = offset_r;
    offset_nxt = offset_r;
    if (clear)
      offset_nxt = lower_s;
    else if (adjusting)
    begin
      cand = raise ? offset_r + $signed({8'h00, step}) : offset_r - $signed({8'h00, step});
      if (cand > upper_s)
        offset_nxt = upper_s;
      else if (cand < lower_s)
        offset_nxt = lower_s;
      else
        offset_nxt = cand;
    end
  end

  // Without memory the offset lapses whenever adjustment is not enabled.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      offset_r <= 32'sd0;
    else if (adjust_memory_setting_i != ITFL_MEM_ON & ~adj_enable)
      offset_r <= 32'sd0;
    else
      offset_r <= offset_nxt;
  end

  // Base plus offset, still in the scale with 8 fraction bits.
  logic signed [31:0] sum;
  assign sum = base_s + offset_r;
  // Output is registered; a negative sum is clamped to zero as a guard.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      adjusted_freq_o <= ITFL_FREQ_RESET;
    else if (sum < 0)
      adjusted_freq_o <= ITFL_FREQ_RESET;
    else
      adjusted_freq_o <= sum[23:8];
  end

  // ****************************************
  // External trip
  // ****************************************
  // Latched until drive reset; a new trip in the reset cycle still wins.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      trip_o <= 1'b0;
    else if (ext_trip)
      trip_o <= 1'b1;
    else if (drive_reset_i)
      trip_o <= 1'b0;
  end
  // The code reads zero outside a trip so a monitor never shows a stale fault.
  assign trip_code_o     = trip_o ? ITFL_TRIP_CODE : 8'h00;
  assign output_enable_o = ~trip_o & run_o;

  // ****************************************
  // Run control
  // ****************************************
  // Three-wire mode needs the terminal block as the run command source.
  logic three_wire;
  assign three_wire = (run_source_setting_i == ITFL_RUN_TERM);

  // Stop has priority over start so a stuck start button cannot override it.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      run_o     <= 1'b0;
      reverse_o <= 1'b0;
    end
    else if (trip_o)
      run_o <= 1'b0;
    else if (three_wire & stop_assigned)
    begin
      if (~stop_in)
        run_o <= 1'b0;
      else if (start)
        run_o <= 1'b1;
      reverse_o <= dir;
    end
    else if (~stop_assigned)
    begin
      run_o     <= fwd ^ rev;
      reverse_o <= rev & ~fwd;
    end
    else
      run_o <= 1'b0;
  end

  // ****************************************
  // Gain selection with taper
  // ****************************************
  // Outside the vector modes the gain switch terminal is ignored entirely.
  logic gain_sel, gain_sel_d_r, bad_param;
  assign gain_sel = gain_sw & (control_method_select_i >= ITFL_CM_VEC_LO) &
                    (control_method_select_i <= ITFL_CM_VEC_HI);
  // P-only gains have a range of their own and are not checked against it.
  assign bad_param = (pi_prop_gain_param_i > ITFL_GAIN_MAX) |
                     (pi_integral_gain_param_i > ITFL_GAIN_MAX) |
                     (alt_pi_prop_gain_i > ITFL_GAIN_MAX) |
                     (alt_pi_integral_gain_i > ITFL_GAIN_MAX) |
                     (gain_taper_time_i > ITFL_TAPER_MAX_MS);
  assign param_error_o = bad_param;

  // Targets follow the selection at once; the taper smooths the outputs.
  logic [13:0] tgt_kp, tgt_ki, tgt_kpp;
  assign tgt_kp  = gain_sel ? alt_pi_prop_gain_i : pi_prop_gain_param_i;
  assign tgt_ki  = gain_sel ? alt_pi_integral_gain_i : pi_integral_gain_param_i;
  assign tgt_kpp = gain_sel ? alt_p_only_gain_i : p_only_gain_param_i;

  // Taper: per millisecond tick, move the gap divided by the ms left (at least one unit) toward target; coarse but monotonic.
  logic [13:0] ms_left_r;
  logic [16:0] tick_r;
  logic        tick;
  // The millisecond tick runs free, so the first taper step may come early.
  assign tick = (tick_r == 17'(ITFL_MS_CYCLES - 1));
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gain_sel_d_r <= 1'b0;
      ms_left_r    <= 14'd0;
      tick_r       <= 17'd0;
    end
    else
    begin
      gain_sel_d_r <= gain_sel;
      tick_r       <= tick ? 17'd0 : tick_r + 17'd1;
      if (gain_sel != gain_sel_d_r)
        ms_left_r <= gain_taper_time_i;
      else if (tick & (ms_left_r != 14'd0))
        ms_left_r <= ms_left_r - 14'd1;
    end
  end
  assign gain_alt_o = gain_sel_d_r;

  // One taper step: close the gap evenly over the milliseconds left.
  function automatic logic [13:0] ramp_to(input logic [13:0] cur,
                                          input logic [13:0] tgt,
                                          input logic [13:0] left);
    logic [13:0] d;
    d = (tgt > cur) ? tgt - cur : cur - tgt;
    if (left == 14'd0)
      return tgt;
    d = d / left;
    if (d == 14'd0)
      d = 14'd1;
    return (tgt > cur) ? cur + d : (tgt < cur) ? cur - d : cur;
  endfunction

  // Rejected parameters leave the previous gains in force.
  // Gains hold in the cycle the selection flips, so the freshly loaded
  // taper time governs the first step instead of the finished previous one.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      kp_o  <= 14'd0;
      ki_o  <= 14'd0;
      kpp_o <= 14'd0;
    end
    else if (~bad_param & (gain_sel == gain_sel_d_r) & (tick | (ms_left_r == 14'd0)))
    begin
      kp_o  <= ramp_to(kp_o, tgt_kp, ms_left_r);
      ki_o  <= ramp_to(ki_o, tgt_ki, ms_left_r);
      kpp_o <= ramp_to(kpp_o, tgt_kpp, ms_left_r);
    end
  end
endmodule

// >>> verification/itfl_contacts.sv
// Purpose: Model of the external contacts that drive the eight terminals.
// Assumes: Contact levels are given by the bench at the falling edge.
// Notes:   With power gone the contacts are frozen, never toggled.
`timescale 1ns/1ps
module itfl_contacts
(
  input  wire logic       mclk_i,
  input  wire logic       power_ok_i,
  input  wire logic [7:0] press_i,
  output logic      [7:0] terminal_o
);
  logic [7:0] held_r;
  // Remember the last levels so nothing moves while power is off.
  always_ff @(posedge mclk_i)
  begin
    if (power_ok_i)
      held_r <= press_i;
  end
  // Raise, lower and trip contacts stay still once power is removed.
  assign terminal_o = power_ok_i ? press_i : held_r;
endmodule

// >>> verification/itfl_terminal_logic_chk.sv
// Purpose: Port-level assertions for the terminal function logic.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Terminal decode is repeated here from the assignment bytes.
`timescale 1ns/1ps
module itfl_terminal_logic_chk
  import itfl_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  terminal_i,
  input  wire logic [63:0] terminal_function_assign_i,
  input  wire logic [1:0]  frequency_source_setting_i,
  input  wire logic [2:0]  control_method_select_i,
  input  wire logic        drive_reset_i,
  input  wire logic [15:0] max_freq_i,
  input  wire logic [13:0] alt_pi_integral_gain_i,
  input  wire logic [15:0] adjusted_freq_o,
  input  wire logic        adjust_active_o,
  input  wire logic [1:0]  ramp_set_o,
  input  wire logic        trip_o,
  input  wire logic [7:0]  trip_code_o,
  input  wire logic        output_enable_o,
  input  wire logic        gain_alt_o
);
  // True when some terminal carrying this function code is on.
  function automatic logic on(input logic [7:0] c, input logic [63:0] fa,
                              input logic [7:0] t);
    on = 1'b0;
    for (int n = 0; n < 8; n++)
      if (fa[8*n +: 8] == c && t[n])
        on = 1'b1;
  endfunction
  // Decoded levels live in signals so the assertions see sampled values.
  logic trip_on, raise_on, lower_on, set2_on, third_set_select_on;
  assign trip_on  = on(ITFL_FN_TRIP, terminal_function_assign_i, terminal_i);
  assign raise_on = on(ITFL_FN_RAISE, terminal_function_assign_i, terminal_i);
  assign lower_on = on(ITFL_FN_LOWER, terminal_function_assign_i, terminal_i);
  assign set2_on  = on(ITFL_FN_SET2, terminal_function_assign_i, terminal_i);
  assign third_set_select_on  = on(ITFL_FN_THIRD_SET_SELECT, terminal_function_assign_i, terminal_i);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  a_trip_sets: assert property (trip_on |=> trip_o)
    else $error("trip input did not trip");
  a_trip_latch: assert property (trip_o && !drive_reset_i |=> trip_o)
    else $error("trip latch dropped without reset");
  a_trip_code: assert property (trip_o |-> trip_code_o == ITFL_TRIP_CODE)
    else $error("trip code wrong");
  a_trip_shut: assert property (trip_o |-> !output_enable_o)
    else $error("output live while tripped");
  a_both_hold: assert property (raise_on && lower_on |-> !adjust_active_o)
    else $error("adjust with both inputs on");
  a_analog_idle: assert property (frequency_source_setting_i == 2'h0 |-> !adjust_active_o)
    else $error("adjust with analog source");
  a_ramp_third: assert property (adjust_active_o && third_set_select_on && !set2_on
    |-> ramp_set_o == 2'h2)
    else $error("third ramp set not chosen");
  a_freq_clamp: assert property (adjust_active_o [*3] |-> adjusted_freq_o <= max_freq_i)
    else $error("adjusted frequency above maximum");
  a_gain_method: assert property ((control_method_select_i < ITFL_CM_VEC_LO) [*2]
    |-> !gain_alt_o)
    else $error("gain switched outside vector modes");
  c_trip: cover property (trip_o ##1 !trip_o);
  c_adjust: cover property (adjust_active_o [*8]);
  c_gain: cover property ($rose(gain_alt_o));
endmodule
bind itfl_terminal_logic itfl_terminal_logic_chk itfl_terminal_logic_chk_inst (.*);

// >>> verification/tb_top.sv
// Purpose: Directed bench for the terminal function logic.
// Assumes: Inputs change at the falling edge, checks sit there too.
// Notes:   Gain taper is zero except one check that a nonzero taper holds the gains.
`timescale 1ns/1ps
module tb_top;
  import itfl_pkg::*;
  logic mclk_i = 0, arst_n_i = 0, power_ok = 1, drst = 0, jog = 0;
  logic [7:0] press = 8'h02, terminal;
  logic [63:0] fa = {ITFL_FN_THIRD_SET_SELECT, ITFL_FN_SET2, ITFL_FN_LOWER, ITFL_FN_RAISE,
                     ITFL_FN_DIR, ITFL_FN_START, ITFL_FN_STOP, ITFL_FN_TRIP};
  logic [1:0] fsrc = 2'h2, rsrc = 2'h1, mem = 2'h1;
  logic [2:0] cm = 3'h3;
  logic [13:0] aki = 14'd200;
  logic [15:0] afreq;
  logic [15:0] afin = 16'h0200, opf = 16'h0064, mxf = 16'h0080;
  logic [ITFL_STEP_W-1:0] rs1 = 24'h000100, rs2 = 24'h000200, rs3 = 24'h000300;
  logic [13:0] taper = 14'd0;
  logic act, trip, oe, run, rev, galt, perr;
  logic [1:0] rset;
  logic [7:0] tcode;
  logic [13:0] kp, ki, kpp;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  always #5 mclk_i = ~mclk_i;
  itfl_contacts itfl_contacts_inst (.mclk_i(mclk_i), .power_ok_i(power_ok), .press_i(press),
    .terminal_o(terminal));
  itfl_terminal_logic itfl_terminal_logic_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .terminal_i(terminal), .terminal_function_assign_i(fa), .frequency_source_setting_i(fsrc),
    .run_source_setting_i(rsrc), .adjust_memory_setting_i(mem), .control_method_select_i(cm),
    .drive_reset_i(drst), .jog_active_i(jog), .analog_freq_i(afin),
    .operator_freq_i(opf), .max_freq_i(mxf), .ramp_step1_i(rs1),
    .ramp_step2_i(rs2), .ramp_step3_i(rs3), .pi_prop_gain_param_i(14'd100),
    .pi_integral_gain_param_i(14'd100), .p_only_gain_param_i(14'd100),
    .alt_pi_prop_gain_i(14'd500), .alt_pi_integral_gain_i(aki), .alt_p_only_gain_i(14'd50),
    .gain_taper_time_i(taper), .adjusted_freq_o(afreq), .adjust_active_o(act),
    .ramp_set_o(rset), .trip_o(trip), .trip_code_o(tcode), .output_enable_o(oe), .run_o(run),
    .reverse_o(rev), .kp_o(kp), .ki_o(ki), .kpp_o(kpp), .gain_alt_o(galt), .param_error_o(perr));
  // Wait whole cycles, ending on a falling edge.
  task automatic wt(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // Compare one observed value and count it.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    wt(2);
    arst_n_i = 1;
    press[0] = 1; wt(1);
    chk("trip", 1, trip); chk("tcode", 8'h0C, tcode); chk("oe", 0, oe);
    press[0] = 0; wt(3); chk("latch", 1, trip);
    drst = 1; wt(1); drst = 0; wt(1); chk("unlatch", 0, trip);
    press[2] = 1; wt(1); press[2] = 0; wt(1); chk("run", 1, run);
    press[3] = 1; wt(1); chk("dir", 1, rev); press[3] = 0;
    press[1] = 0; wt(2); chk("stop", 0, run); press[1] = 1;
    fa[63:56] = ITFL_FN_FWD; press[7] = 1; wt(3); chk("fwd", 0, run);
    press[7] = 0; fa[63:56] = ITFL_FN_THIRD_SET_SELECT; rsrc = 0;
    press[2] = 1; wt(1); press[2] = 0; wt(1); chk("src", 0, run); rsrc = 1;
    press[4] = 1; wt(20); chk("act", 1, act); chk("set1", 0, rset);
    press[6] = 1; wt(1); chk("set2", 1, rset); press[6] = 0;
    press[7] = 1; wt(1); chk("third_set_select", 2, rset); press[7] = 0;
    chk("step2", 16'h007A, afreq);
    wt(60); chk("max", 16'h0080, afreq);
    press[5] = 1; wt(5); chk("both", 0, act); chk("hold", 16'h0080, afreq);
    press[4] = 0; wt(200); chk("min", 0, afreq); press[5] = 0;
    press[4] = 1; wt(10); jog = 1; wt(1); chk("jog", 0, act); press[4] = 0;
    wt(2); jog = 0; wt(3); chk("keep", 16'h000A, afreq);
    mem = 0; jog = 1; wt(3); jog = 0; wt(3); chk("drop", 16'h0064, afreq);
    fsrc = 0; press[4] = 1; wt(1); chk("analog", 0, act);
    fsrc = 1; wt(1); chk("nohold", 0, act);
    fa[55:48] = ITFL_FN_HOLD; press[6] = 1; wt(1); chk("held", 1, act);
    press[6] = 0; fa[47:40] = ITFL_FN_NONE; fsrc = 2; wt(1); chk("unasg", 0, act);
    fa[47:40] = ITFL_FN_LOWER; mem = 1; wt(10); press[4] = 0;
    fa[55:48] = ITFL_FN_CLEAR; press[6] = 1; wt(3); chk("clear", 0, afreq);
    press[6] = 0; fa[55:48] = ITFL_FN_GAIN; wt(3);
    chk("kp0", 14'd100, kp); chk("alt0", 0, galt);
    chk("ki0", 14'd100, ki); chk("kpp0", 14'd100, kpp);
    press[6] = 1; wt(3); chk("kp1", 14'd500, kp); chk("alt1", 1, galt);
    chk("ki1", 14'd200, ki); chk("kpp1", 14'd50, kpp);
    cm = 0; wt(3); chk("cm0", 0, galt); chk("kpm", 14'd100, kp);
    cm = 5; wt(3); chk("cm5", 1, galt);
    fa[55:48] = ITFL_FN_NONE; wt(3); chk("none", 0, galt);
    taper = 14'd1; fa[55:48] = ITFL_FN_GAIN; wt(3); chk("taper", 14'd100, kp);
    chk("alt2", 1, galt);
    aki = 14'd10001; wt(1); chk("perr", 1, perr);
    aki = 14'd10000; wt(1); chk("pok", 0, perr);
    power_ok = 0; press = 8'hFF; wt(2);
    tally_and_finish();
  end
endmodule
